/* File: core/cpg_consts.svh */
// Constants of the copper test packet generator
// Notes on behaviour
// RL1 - Burst count zero sends packets without end; 1 to 255 sends that many, then stops.
// RL2 - Trigger/done bit matters only with hold set, generator enabled, burst nonzero.
// RL3 - Trigger/done bit reads one once a burst is complete, zero while sending.
// RL4 - Writing zero to trigger/done while it reads one restarts a burst; else ignored.
// RL5 - Hold clear: enable clears itself after a burst's last packet; hold set: stays.
// RL6 - Error bit set: every packet carries a bad CRC and a symbol error.
// RL7 - Enable, checker enable, payload and length select bits, all resetting to zero.
`ifndef CPG_CONSTS_SVH
`define CPG_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define CPG_CTRL_ADDR 8'h10
`define CPG_STAT_ADDR 8'h14
`define CPG_CTRL_RST 16'h0000
`define CPG_CTRL_WMASK 16'hFF7F
`define CPG_HSIZE_WORD 3'h2

// ****************************************
// Control fields
// ****************************************
`define CPG_BURST_HI 15
`define CPG_BURST_LO 8
`define CPG_TRIG 7
`define CPG_HOLD 6
`define CPG_CHK 4
`define CPG_EN 3
`define CPG_PAT 2
`define CPG_LONG 1
`define CPG_ERR 0

// ****************************************
// Frame layout
// ****************************************
`define CPG_PRE_BYTE 8'h55
`define CPG_SFD_BYTE 8'hD5
`define CPG_PRE_LAST 11'h007
`define CPG_BODY_SHORT 11'h03C
`define CPG_BODY_LONG 11'h5EA
`define CPG_FCS_LAST 11'h003
`define CPG_IPG_LEN 11'h00C
`define CPG_PAT_A 8'h5A
`define CPG_PAT_B 8'hA5
`define CPG_CRC_INIT 32'hFFFFFFFF
`define CPG_CRC_POLY 32'hEDB88320
`define CPG_LFSR_SEED 16'hACE1
`define CPG_LFSR_TAPS 16'hB400
`define CPG_FIFO_W 10
`define CPG_FIFO_D 32

`endif

/* File: core/cpg_crc_step.sv */
// One byte step of a reflected CRC
`timescale 1ns/1ps
`default_nettype none
module cpg_crc_step #(
  parameter logic [31:0] POLY = 32'h04C11DB7
) (
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [31:0] crc_out
);
  always_comb begin
    logic [31:0] c;
    c = crc_in ^ {24'h000000, data_in};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ({1'b0, c[31:1]} ^ POLY) : {1'b0, c[31:1]};
    end
    crc_out = c;
  end
endmodule // cpg_crc_step
`default_nettype wire

/* File: core/cpg_fifo.sv */
// Byte FIFO with a registered output stage
`timescale 1ns/1ps
`default_nettype none
module cpg_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  // Refill the output stage when it is empty or being drained
  assign pop = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // A stalled sink must see the same byte until it takes it
  out_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data))) else $error("Output changed before taken");

  fill_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    count <= (AW+1)'(DEPTH)) else $error("FIFO count past depth");
endmodule // cpg_fifo
`default_nettype wire

/* File: core/cpg_pkg.sv */
// Types of the copper test packet generator
package cpg_pkg;
  typedef enum logic [2:0] {
    cpg_idle = 3'h0,
    cpg_pre = 3'h1,
    cpg_body = 3'h2,
    cpg_fcs = 3'h3,
    cpg_gap = 3'h4
  } cpg_state_t;
endpackage

/* File: core/cpg_top.sv */
// Copper test packet generator with AHB-Lite control register
`timescale 1ns/1ps
`default_nettype none
`include "cpg_consts.svh"
module cpg_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_last,
  output logic tx_err,
  input wire logic tx_ready,
  output logic crc_check_en
);
  import cpg_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] ctrl;
  logic done;
  logic running;
  logic cont;
  logic [7:0] left;
  logic [15:0] sent_cnt;
  logic rd_pend;
  logic wr_pend;
  logic [7:0] rd_addr;
  logic [7:0] wr_addr;
  logic [31:0] rd_mux;
  logic accept;
  logic wr_ctrl;
  logic [15:0] wdat;
  logic wdat_chk;
  logic en_rise;
  logic trig_ok;
  logic restart;
  logic start;
  logic pkt_end;
  logic burst_end;
  cpg_state_t state;
  logic [10:0] cnt;
  logic [10:0] body_last;
  logic [31:0] crc;
  logic [31:0] next_crc;
  logic [31:0] fcs;
  logic [15:0] lfsr;
  logic pat_lat;
  logic long_lat;
  logic err_lat;
  logic push_valid;
  logic push_ready;
  logic [7:0] push_byte;
  logic push_last;
  logic push_err;
  logic [`CPG_FIFO_W-1:0] fifo_out;
  logic [7:0] pkt_in_burst;
  logic [7:0] burst_len;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Reads take one wait state so a write just before them is already visible
  assign accept = hsel && hready && htrans[1] && (hsize == `CPG_HSIZE_WORD) && !rd_pend;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
      rd_addr <= 8'h00;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= 1'b0;
      if (rd_pend) begin
        hrdata <= rd_mux;
        hreadyout <= 1'b1;
        rd_pend <= 1'b0;
      end else if (accept && !hwrite) begin
        rd_pend <= 1'b1;
        rd_addr <= haddr[7:0];
        hreadyout <= 1'b0;
      end else if (accept && hwrite) begin
        wr_pend <= 1'b1;
        wr_addr <= haddr[7:0];
      end
    end
  end

  always_comb begin
    case (rd_addr)
      `CPG_CTRL_ADDR: rd_mux = {16'h0000, ctrl[15:8], done, ctrl[6:0]}; // RL3
      `CPG_STAT_ADDR: rd_mux = {15'h0000, running, sent_cnt};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ****************************************
  // Control decode
  // ****************************************
  assign wr_ctrl = wr_pend && (wr_addr == `CPG_CTRL_ADDR);
  assign wdat = hwdata[15:0];
  assign wdat_chk = wdat[`CPG_CHK];
  assign en_rise = wr_ctrl && wdat[`CPG_EN] && !ctrl[`CPG_EN];
  assign trig_ok = ctrl[`CPG_HOLD] && ctrl[`CPG_EN] && (ctrl[`CPG_BURST_HI:`CPG_BURST_LO] != 8'h00); // RL2
  assign restart = wr_ctrl && !wdat[`CPG_TRIG] && done && trig_ok && !running; // RL4
  assign start = en_rise || restart;
  assign pkt_end = (state == cpg_gap) && (cnt == `CPG_IPG_LEN - 11'h001);
  assign burst_end = pkt_end && !cont && (left == 8'h01); // RL1

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `CPG_CTRL_RST; // RL7
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdat & `CPG_CTRL_WMASK; // RL7
      end
      if (burst_end && !ctrl[`CPG_HOLD]) begin
        ctrl[`CPG_EN] <= 1'b0; // RL5
      end
    end
  end
  assign crc_check_en = ctrl[`CPG_CHK];

  // ****************************************
  // Burst sequencing
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running <= 1'b0;
      done <= 1'b0;
      cont <= 1'b0;
      left <= 8'h00;
    end else begin
      if (start) begin
        running <= 1'b1;
        done <= 1'b0;
        left <= wdat[`CPG_BURST_HI:`CPG_BURST_LO];
        cont <= (wdat[`CPG_BURST_HI:`CPG_BURST_LO] == 8'h00); // RL1
      end else if (pkt_end) begin
        if (!cont) left <= left - 8'h01;
        // Disabling mid-frame lets the frame finish instead of truncating it
        if (!ctrl[`CPG_EN]) running <= 1'b0;
      end
      // Completion set comes last so it wins over any clear
      if (burst_end) begin
        running <= 1'b0;
        done <= 1'b1; // RL3
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sent_cnt <= 16'h0000;
    end else if (pkt_end) begin
      sent_cnt <= sent_cnt + 16'h0001;
    end
  end

  // ****************************************
  // Frame generator
  // ****************************************
  // Stalls on a full FIFO; only idle and the gap run regardless of back-pressure
  assign body_last = (long_lat ? `CPG_BODY_LONG : `CPG_BODY_SHORT) - 11'h001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= cpg_idle;
      cnt <= 11'h000;
      pat_lat <= 1'b0;
      long_lat <= 1'b0;
      err_lat <= 1'b0;
    end else begin
      unique case (state)
        cpg_idle: begin
          if (running) begin
            state <= cpg_pre;
            cnt <= 11'h000;
            pat_lat <= ctrl[`CPG_PAT];
            long_lat <= ctrl[`CPG_LONG];
            err_lat <= ctrl[`CPG_ERR]; // RL6
          end
        end
        cpg_pre: begin
          if (push_ready) begin
            if (cnt == `CPG_PRE_LAST) begin
              state <= cpg_body;
              cnt <= 11'h000;
            end else begin
              cnt <= cnt + 11'h001;
            end
          end
        end
        cpg_body: begin
          if (push_ready) begin
            if (cnt == body_last) begin
              state <= cpg_fcs;
              cnt <= 11'h000;
            end else begin
              cnt <= cnt + 11'h001;
            end
          end
        end
        cpg_fcs: begin
          if (push_ready) begin
            if (cnt == `CPG_FCS_LAST) begin
              state <= cpg_gap;
              cnt <= 11'h000;
            end else begin
              cnt <= cnt + 11'h001;
            end
          end
        end
        cpg_gap: begin
          if (pkt_end) begin
            state <= cpg_idle;
            cnt <= 11'h000;
          end else begin
            cnt <= cnt + 11'h001;
          end
        end
        default: begin
          state <= cpg_idle;
          cnt <= 11'h000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc <= `CPG_CRC_INIT;
    end else if (state == cpg_idle) begin
      crc <= `CPG_CRC_INIT;
    end else if ((state == cpg_body) && push_ready) begin
      crc <= next_crc;
    end
  end

  // Steps only on accepted body bytes and is not reseeded between frames, so successive payloads differ
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lfsr <= `CPG_LFSR_SEED;
    end else if ((state == cpg_body) && push_ready) begin
      lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `CPG_LFSR_TAPS : 16'h0000);
    end
  end

  cpg_crc_step #(
    .POLY(`CPG_CRC_POLY)
  ) u_crc (
    .crc_in(crc),
    .data_in(push_byte),
    .crc_out(next_crc)
  );

  // A frame check word left uninverted is always wrong
  assign fcs = err_lat ? crc : ~crc; // RL6

  always_comb begin
    push_byte = 8'h00;
    push_last = 1'b0;
    push_err = 1'b0;
    push_valid = 1'b0;
    case (state)
      cpg_pre: begin
        push_valid = 1'b1;
        push_byte = (cnt == `CPG_PRE_LAST) ? `CPG_SFD_BYTE : `CPG_PRE_BYTE;
      end
      cpg_body: begin
        push_valid = 1'b1;
        if (pat_lat) push_byte = cnt[0] ? `CPG_PAT_B : `CPG_PAT_A;
        else push_byte = lfsr[7:0];
      end
      cpg_fcs: begin
        push_valid = 1'b1;
        case (cnt[1:0])
          2'h0: push_byte = fcs[7:0];
          2'h1: push_byte = fcs[15:8];
          2'h2: push_byte = fcs[23:16];
          default: push_byte = fcs[31:24];
        endcase
        push_last = (cnt == `CPG_FCS_LAST);
        push_err = err_lat && push_last; // RL6
      end
      default: begin
        push_valid = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Output FIFO
  // ****************************************
  logic fifo_in_ready;
  assign push_ready = push_valid && fifo_in_ready;

  cpg_fifo #(
    .WIDTH(`CPG_FIFO_W),
    .DEPTH(`CPG_FIFO_D)
  ) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data({push_err, push_last, push_byte}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(fifo_out)
  );

  assign tx_data = fifo_out[7:0];
  assign tx_last = fifo_out[8];
  assign tx_err = fifo_out[9];

  // ****************************************
  // Checks
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pkt_in_burst <= 8'h00;
      burst_len <= 8'h00;
    end else if (start) begin
      pkt_in_burst <= 8'h00;
      burst_len <= wdat[`CPG_BURST_HI:`CPG_BURST_LO];
    end else if (pkt_end) begin
      pkt_in_burst <= pkt_in_burst + 8'h01;
    end
  end

  burst_count_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
    burst_end |-> ((pkt_in_burst + 8'h01) == burst_len)) else $error("Burst ends at wrong packet count");
  cont_runs_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
    (pkt_end && cont && ctrl[`CPG_EN] && !start) |=> running) else $error("Continuous mode stopped");
  trig_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
    (wr_ctrl && done && !trig_ok && !en_rise && !burst_end) |=> done) else $error("Trigger acted while invalid");
  done_reads_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
    burst_end |=> (done && !running) ##1 (done || $past(start))) else $error("Done flag not set after burst");
  busy_not_done_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL3
    (running && !burst_end) |=> !done || !running) else $error("Done while still sending");
  restart_go_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
    restart |=> (running && !done) ##[1:2] (state == cpg_pre)) else $error("Restart did not start a burst");
  self_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL5
    (burst_end && ctrl[`CPG_EN] && !wr_ctrl) |=> (ctrl[`CPG_EN] == $past(ctrl[`CPG_HOLD])))
    else $error("Enable self clear wrong");
  err_frame_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
    (tx_valid && tx_err) |-> tx_last) else $error("Symbol error off the last byte");
  chk_bit_a: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
    wr_ctrl |=> (crc_check_en == $past(wdat_chk))) else $error("Checker enable not stored");
endmodule // cpg_top
`default_nettype wire

/* File: tb/cpg_sink.sv */
// Link partner model that takes the test frames and checks them
`timescale 1ns/1ps
`default_nettype none
module cpg_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic tx_err,
  output logic tx_ready,
  output int frames,
  output int bad_crc,
  output int err_frames,
  output int bad_pre,
  output int last_len
);
  // ****************************************
  // Frame checking
  // ****************************************
  int len;
  logic [31:0] crc;
  logic [3:0] ph;
  function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    return c;
  endfunction
  // Slow mode drops ready in an uneven pattern so the FIFO fills and drains
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b1;
      ph <= 4'h0;
      len <= 0;
      crc <= 32'hFFFFFFFF;
      frames <= 0;
      bad_crc <= 0;
      err_frames <= 0;
      bad_pre <= 0;
      last_len <= 0;
    end else begin
      ph <= ph + 4'h1;
      tx_ready <= !slow || (ph[2] ^ ph[0]);
      if (tx_valid && tx_ready) begin
        len <= tx_last ? 0 : len + 1;
        crc <= (len < 8 || tx_last) ? 32'hFFFFFFFF : step(crc, tx_data);
        if ((len < 7 && tx_data !== 8'h55) || (len == 7 && tx_data !== 8'hD5)) begin
          bad_pre <= bad_pre + 1;
        end
        if (tx_last) begin
          frames <= frames + 1;
          last_len <= len + 1;
          // Good frames leave the fixed residue over data and FCS
          if (step(crc, tx_data) !== 32'hDEBB20E3) begin
            bad_crc <= bad_crc + 1;
          end
          if (tx_err === 1'b1) begin
            err_frames <= err_frames + 1;
          end
        end
      end
    end
  end
endmodule // cpg_sink
`default_nettype wire

/* File: tb/test_cpg_top.sv */
// Testbench of the copper test packet generator
`timescale 1ns/1ps
`default_nettype none
`include "cpg_consts.svh"
module test_cpg_top;
  localparam logic [31:0] CTRL = {24'h000000, `CPG_CTRL_ADDR};
  localparam logic [31:0] STAT = {24'h000000, `CPG_STAT_ADDR};
  localparam logic [31:0] EN = 32'h8;
  localparam logic [31:0] HOLD = 32'h40;
  localparam logic [31:0] PAT = 32'h4;
  localparam logic [31:0] LONG = 32'h2;
  localparam logic [31:0] ERR = 32'h1;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = `CPG_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, tx_valid, tx_last, tx_err, tx_ready, crc_check_en;
  wire logic [7:0] tx_data;
  int frames, bad_crc, err_frames, bad_pre, last_len, f0;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  always #2.5 hclk = ~hclk;
  cpg_top u_cpg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_err(tx_err), .tx_ready(tx_ready), .crc_check_en(crc_check_en));
  cpg_sink u_cpg_sink (.clk(hclk), .rst_n(hresetn), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_err(tx_err), .tx_ready(tx_ready), .frames(frames), .bad_crc(bad_crc),
    .err_frames(err_frames), .bad_pre(bad_pre), .last_len(last_len));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hangs in the wait loops are cut by the cycle ceiling below
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    check(32'(hresp), 32'h0, "okay response");
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic wait_done;
    rd = 32'h0;
    for (int i = 0; i < 4000 && rd[`CPG_TRIG] !== 1'b1; i++) rd_reg(CTRL, rd);
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      give_verdict;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_reg(CTRL, rd);
    check(rd, 32'h0, "ctrl reset");
    check(32'(crc_check_en), 32'h0, "checker reset");
    wr(CTRL, 32'h34);
    rd_reg(CTRL, rd);
    check(rd, 32'h34, "ctrl readback");
    check(32'(crc_check_en), 32'h1, "checker on");
    rd_reg(32'h20, rd);
    check(rd, 32'h0, "unmapped read");
    // Burst of three short frames, enable clears itself
    wr(CTRL, 32'h0300 | EN | PAT);
    rd_reg(CTRL, rd);
    check(32'(rd[`CPG_TRIG]), 32'h0, "busy flag");
    wait_done;
    check(rd, 32'h0380 | PAT, "self clear");
    repeat (300) @(posedge hclk);
    check(frames, 32'h3, "burst count");
    check(last_len, 32'h48, "short length");
    check(bad_crc + err_frames + bad_pre, 32'h0, "clean frames");
    rd_reg(STAT, rd);
    check(rd, 32'h3, "sent count");
    // Trigger without hold and enable must do nothing
    wr(CTRL, 32'h0100);
    repeat (200) @(posedge hclk);
    check(frames, 32'h3, "no trigger");
    // Hold set, errored long frames, sink stalling
    slow <= 1'b1;
    wr(CTRL, 32'h0200 | HOLD | EN | LONG | ERR);
    wait_done;
    check(rd, 32'h0280 | HOLD | EN | LONG | ERR, "hold keeps enable");
    repeat (300) @(posedge hclk);
    check(frames, 32'h5, "two more");
    check(last_len, 32'h5F6, "long length");
    check(err_frames, 32'h2, "symbol errors");
    check(bad_crc, 32'h2, "bad crc");
    slow <= 1'b0;
    wr(CTRL, 32'h0180 | HOLD | EN);
    repeat (200) @(posedge hclk);
    check(frames, 32'h5, "write one ignored");
    wr(CTRL, 32'h0100 | HOLD | EN);
    rd_reg(CTRL, rd);
    check(32'(rd[`CPG_TRIG]), 32'h0, "restart busy");
    // Second zero write lands while sending and must not add a frame
    wr(CTRL, 32'h0100 | HOLD | EN);
    wait_done;
    repeat (200) @(posedge hclk);
    check(frames, 32'h6, "restart one");
    check(bad_crc + bad_pre, 32'h2, "good again");
    // Enable must rise again; bit 7 set on the clearing write keeps it from restarting
    wr(CTRL, 32'h0080);
    wr(CTRL, EN);
    repeat (1000) @(posedge hclk);
    check(32'(frames >= 16), 32'h1, "continuous");
    wr(CTRL, 32'h0);
    repeat (200) @(posedge hclk);
    f0 = frames;
    repeat (300) @(posedge hclk);
    check(frames, f0, "stopped");
    give_verdict;
  end
endmodule // test_cpg_top
`default_nettype wire
